// File: logic/bsl_alu.sv
// bsl_alu.sv: decode and combinational datapath for one instruction word
// assumes: same-clock inputs; file operand already read for the address given
`timescale 1ns/1ps
`include "bsl_params.svh"

module bsl_alu (
    input wire logic [`BSL_IW_W-1:0] i_instr,
    input wire logic [7:0] i_acc,
    input wire logic [7:0] i_file,
    output bsl_pkg::bsl_op_type o_op,
    output logic [7:0] o_result,
    output logic o_result_zero
);
    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    function automatic bsl_pkg::bsl_op_type decode(input logic [`BSL_IW_W-1:0] iw);
        logic [5:0] op6;
        op6 = iw[`BSL_OP6_HI:`BSL_OP6_LO];
        if (iw[`BSL_OP3_HI:`BSL_OP3_LO] == `BSL_OP3_BRANCH) begin
            decode = bsl_pkg::BSL_OP_BRANCH;
        end else if (op6 == `BSL_OP_DECSKIP) begin
            decode = bsl_pkg::BSL_OP_DEC_SKIP;
        end else if (op6 == `BSL_OP_INCSKIP) begin
            decode = bsl_pkg::BSL_OP_INC_SKIP;
        end else if (op6 == `BSL_OP_INCREMENT_FILE) begin
            decode = bsl_pkg::BSL_OP_INC_FILE;
        end else if (op6 == `BSL_OP_ORFILE) begin
            decode = bsl_pkg::BSL_OP_OR_FILE;
        end else if (op6[5:2] == 4'(`BSL_OP_ORLIT >> 2)) begin
            // low two opcode bits are don't-care for the literal form
            decode = bsl_pkg::BSL_OP_OR_LIT;
        end else begin
            decode = bsl_pkg::BSL_OP_NONE;
        end
    endfunction : decode

    // ------------------------------------------------------------------
    // datapath
    // ------------------------------------------------------------------
    always_comb begin
        o_op = decode(i_instr);
        case (o_op)
            bsl_pkg::BSL_OP_DEC_SKIP: o_result = i_file - 8'h01;
            bsl_pkg::BSL_OP_INC_SKIP, bsl_pkg::BSL_OP_INC_FILE: begin
                o_result = i_file + 8'h01;
            end
            bsl_pkg::BSL_OP_OR_FILE: o_result = i_acc | i_file;
            bsl_pkg::BSL_OP_OR_LIT: o_result = i_acc | i_instr[`BSL_K8_HI:`BSL_K8_LO];
            default: o_result = 8'h00;
        endcase
        o_result_zero = (o_result == 8'h00);
    end
endmodule : bsl_alu

// File: logic/bsl_core.sv
// bsl_core.sv: execution of skip, increment, inclusive-or and branch
// assumes: one instruction word per cycle on i_instr with i_instr_valid;
// file register read data i_file_rdata matches the address field of
// i_instr combinationally; fetch follows o_pc; writes land on o_file_we.
// How it works
// - destination bit 0 writes accumulator, 1 writes file; address 0..127
// - decrement-skip: file minus one, zero result flushes next slot, no flags
// - increment-skip: file plus one, zero result flushes next slot, no flags
// - branch loads 11-bit immediate into pc low bits, two cycles, no flags
// - branch fills pc bits 14:11 from upper address latch bits 6:3
// - or-literal: accumulator or 8-bit literal into accumulator, zero flag updated
// - increment-file: file plus one to destination, zero flag, never skips
// - or-acc-with-file: accumulator or file to destination, zero flag updated
`timescale 1ns/1ps
`include "bsl_params.svh"

module bsl_core (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_instr_valid,
    input wire logic [`BSL_IW_W-1:0] i_instr,
    input wire logic [7:0] i_file_rdata,
    input wire logic [7:0] i_upper_address_latch,
    output logic [`BSL_PC_W-1:0] o_pc,
    output logic [7:0] o_acc,
    output logic o_zero,
    output logic o_file_we,
    output logic [6:0] o_file_addr,
    output logic [7:0] o_file_wdata,
    output logic o_flush
);
    bsl_pkg::bsl_op_type op;
    logic [7:0] result;
    logic result_zero;

    bsl_alu u_alu (
        .i_instr(i_instr),
        .i_acc(o_acc),
        .i_file(i_file_rdata),
        .o_op(op),
        .o_result(result),
        .o_result_zero(result_zero)
    );

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    bsl_pkg::bsl_state_type state_q, state_d;
    logic [`BSL_PC_W-1:0] pc_d;
    logic [7:0] acc_d;
    logic zero_d;
    logic file_we_d;
    logic [6:0] file_addr_d;
    logic [7:0] file_wdata_d;
    logic flush_d;
    logic dest_file;
    logic exec;

    // sequential advance, shared by executed and discarded slots
    function automatic logic [`BSL_PC_W-1:0] pc_step(input logic [`BSL_PC_W-1:0] pc);
        pc_step = pc + 15'h0001;
    endfunction : pc_step

    always_comb begin
        state_d = state_q;
        pc_d = o_pc;
        acc_d = o_acc;
        zero_d = o_zero;
        file_we_d = 1'b0;
        file_addr_d = o_file_addr;
        file_wdata_d = o_file_wdata;
        flush_d = 1'b0;
        dest_file = i_instr[`BSL_DEST_BIT];
        exec = 1'b0;
        case (state_q)
            bsl_pkg::BSL_ST_FLUSH: begin
                // slot of a taken skip or branch: nothing is written
                if (i_instr_valid) begin
                    state_d = bsl_pkg::BSL_ST_EXEC;
                    pc_d = pc_step(o_pc);
                end
            end
            bsl_pkg::BSL_ST_EXEC: begin
                exec = i_instr_valid;
            end
            default: state_d = bsl_pkg::BSL_ST_EXEC;
        endcase
        if (exec) begin
            pc_d = pc_step(o_pc);
            case (op)
                bsl_pkg::BSL_OP_BRANCH: begin
                    pc_d = {i_upper_address_latch[`BSL_LATCH_HI:`BSL_LATCH_LO],
                            i_instr[`BSL_K11_HI:`BSL_K11_LO]};
                    state_d = bsl_pkg::BSL_ST_FLUSH;
                    flush_d = 1'b1;
                end
                bsl_pkg::BSL_OP_OR_LIT: begin
                    acc_d = result;
                    zero_d = result_zero;
                end
                bsl_pkg::BSL_OP_NONE: ;
                default: begin
                    // file forms: route by destination bit
                    if (dest_file) begin
                        file_we_d = 1'b1;
                        file_addr_d = i_instr[`BSL_FADDR_HI:`BSL_FADDR_LO];
                        file_wdata_d = result;
                    end else begin
                        acc_d = result;
                    end
                    if (op == bsl_pkg::BSL_OP_INC_FILE || op == bsl_pkg::BSL_OP_OR_FILE) begin
                        zero_d = result_zero;
                    end
                    if ((op == bsl_pkg::BSL_OP_DEC_SKIP || op == bsl_pkg::BSL_OP_INC_SKIP)
                            && result_zero) begin
                        state_d = bsl_pkg::BSL_ST_FLUSH;
                        flush_d = 1'b1;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            state_q <= bsl_pkg::BSL_ST_EXEC;
            o_pc <= `BSL_RST_PC;
            o_acc <= `BSL_RST_ACC;
            o_zero <= `BSL_RST_ZERO;
            o_file_we <= 1'b0;
            o_file_addr <= 7'h00;
            o_file_wdata <= 8'h00;
            o_flush <= 1'b0;
        end else begin
            state_q <= state_d;
            o_pc <= pc_d;
            o_acc <= acc_d;
            o_zero <= zero_d;
            o_file_we <= file_we_d;
            o_file_addr <= file_addr_d;
            o_file_wdata <= file_wdata_d;
            o_flush <= flush_d;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);

    logic in_flush;
    assign in_flush = (state_q == bsl_pkg::BSL_ST_FLUSH);

    logic file_op;
    assign file_op = (op == bsl_pkg::BSL_OP_DEC_SKIP) || (op == bsl_pkg::BSL_OP_INC_SKIP)
        || (op == bsl_pkg::BSL_OP_INC_FILE) || (op == bsl_pkg::BSL_OP_OR_FILE);

    AST_DEST_ROUTE: assert property (
        exec && op == bsl_pkg::BSL_OP_INC_FILE && dest_file
        |=> o_file_we && o_file_wdata == $past(i_file_rdata) + 8'h01)
        else $error("file destination not written");
    AST_DEST_ADDR: assert property (
        exec && file_op && dest_file |=> o_file_addr == $past(i_instr[6:0]))
        else $error("file write address wrong");
    AST_DEST_ACC: assert property (
        exec && op == bsl_pkg::BSL_OP_OR_FILE && !dest_file
        |=> !o_file_we && o_acc == ($past(o_acc) | $past(i_file_rdata)))
        else $error("accumulator destination wrong");
    AST_DEC_SKIP: assert property (
        exec && op == bsl_pkg::BSL_OP_DEC_SKIP && i_file_rdata == 8'h01
        |=> in_flush && o_flush && $stable(o_zero))
        else $error("decrement to zero did not skip");
    AST_DEC_NOSKIP: assert property (
        exec && op == bsl_pkg::BSL_OP_DEC_SKIP && i_file_rdata != 8'h01
        |=> !in_flush && !o_flush && $stable(o_zero))
        else $error("decrement to non-zero skipped");
    AST_INC_SKIP: assert property (
        exec && op == bsl_pkg::BSL_OP_INC_SKIP && i_file_rdata == 8'hff
        |=> in_flush && o_flush && $stable(o_zero))
        else $error("increment to zero did not skip");
    AST_BRANCH_LOW: assert property (
        exec && op == bsl_pkg::BSL_OP_BRANCH
        |=> o_pc[10:0] == $past(i_instr[10:0]) && in_flush)
        else $error("branch target low bits wrong");
    AST_BRANCH_FLAGS: assert property (
        exec && op == bsl_pkg::BSL_OP_BRANCH
        |=> $stable(o_zero) && $stable(o_acc) && !o_file_we)
        else $error("branch changed a register or flag");
    AST_BRANCH_HIGH: assert property (
        exec && op == bsl_pkg::BSL_OP_BRANCH
        |=> o_pc[14:11] == $past(i_upper_address_latch[6:3]))
        else $error("branch target high bits wrong");
    AST_OR_LIT: assert property (
        exec && op == bsl_pkg::BSL_OP_OR_LIT
        |=> o_acc == ($past(o_acc) | $past(i_instr[7:0])))
        else $error("or literal result wrong");
    AST_INC_NOSKIP: assert property (
        exec && op == bsl_pkg::BSL_OP_INC_FILE |=> !in_flush)
        else $error("plain increment skipped");
    AST_OR_FILE_ZERO: assert property (
        exec && op == bsl_pkg::BSL_OP_OR_FILE
        |=> o_zero == ($past(o_acc | i_file_rdata) == 8'h00))
        else $error("or file zero flag wrong");
    AST_ZERO_FLAG: assert property (
        exec && op == bsl_pkg::BSL_OP_INC_FILE && i_file_rdata == 8'hff |=> o_zero)
        else $error("zero flag not set");
    AST_ZERO_CLEAR: assert property (
        exec && op == bsl_pkg::BSL_OP_OR_LIT && (o_acc | i_instr[7:0]) != 8'h00
        |=> !o_zero)
        else $error("zero flag not cleared");
    AST_FLUSH_QUIET: assert property (
        in_flush |=> !o_file_we && $stable(o_acc) && $stable(o_zero))
        else $error("flushed slot changed state");
    AST_FLUSH_PC: assert property (
        in_flush && i_instr_valid
        |=> !in_flush && !o_flush && o_pc == $past(o_pc) + 15'h0001)
        else $error("discarded slot did not advance");
    AST_ONE_CYCLE: assert property (
        exec && (op == bsl_pkg::BSL_OP_OR_LIT || op == bsl_pkg::BSL_OP_OR_FILE
        || op == bsl_pkg::BSL_OP_INC_FILE)
        |=> !in_flush && o_pc == $past(o_pc) + 15'h0001)
        else $error("plain op took more than one cycle");

    COV_SKIP: cover property (exec && op == bsl_pkg::BSL_OP_DEC_SKIP ##1 in_flush);
    COV_BRANCH: cover property (exec && op == bsl_pkg::BSL_OP_BRANCH ##1 in_flush);
    COV_FILE_WR: cover property (o_file_we);
    COV_OR_LIT: cover property (exec && op == bsl_pkg::BSL_OP_OR_LIT);
    COV_DISCARD: cover property (in_flush && i_instr_valid);
endmodule : bsl_core

// File: logic/bsl_params.svh
// bsl_params.svh: constants for the branch/skip/logic execution block
// assumes: included by bare name from the package and the design modules
`ifndef BSL_PARAMS_SVH
`define BSL_PARAMS_SVH

// ----------------------------------------------------------------------
// instruction word fields (14-bit word)
// ----------------------------------------------------------------------
`define BSL_IW_W 14
`define BSL_OP6_HI 13
`define BSL_OP6_LO 8
`define BSL_OP3_HI 13
`define BSL_OP3_LO 11
`define BSL_DEST_BIT 7
`define BSL_FADDR_HI 6
`define BSL_FADDR_LO 0
`define BSL_K8_HI 7
`define BSL_K8_LO 0
`define BSL_K11_HI 10
`define BSL_K11_LO 0

// ----------------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------------
`define BSL_OP_DECSKIP 6'h0b
`define BSL_OP_INCSKIP 6'h0f
`define BSL_OP_INCREMENT_FILE 6'h0a
`define BSL_OP_ORFILE 6'h04
`define BSL_OP_ORLIT 6'h38
`define BSL_OP3_BRANCH 3'h5

// ----------------------------------------------------------------------
// program counter and latch
// ----------------------------------------------------------------------
`define BSL_PC_W 15
`define BSL_LATCH_HI 6
`define BSL_LATCH_LO 3

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define BSL_RST_ACC 8'h00
`define BSL_RST_PC 15'h0000
`define BSL_RST_ZERO 1'b0

`endif

// File: logic/bsl_pkg.sv
// bsl_pkg.sv: types for the branch/skip/logic execution block
// assumes: bsl_params.svh on the include path
`include "bsl_params.svh"

package bsl_pkg;
    typedef enum logic [2:0] {
        BSL_OP_NONE,
        BSL_OP_DEC_SKIP,
        BSL_OP_INC_SKIP,
        BSL_OP_INC_FILE,
        BSL_OP_OR_FILE,
        BSL_OP_OR_LIT,
        BSL_OP_BRANCH
    } bsl_op_type;

    typedef enum logic [1:0] {
        BSL_ST_EXEC,
        BSL_ST_FLUSH
    } bsl_state_type;
endpackage : bsl_pkg

// File: verif/branch_skip_logic_ops_tb.sv
// branch_skip_logic_ops_tb.sv: self-checking bench for the bsl_core execution block
// assumes: bsl_params.svh on the include path; no partner, the bench drives every port
`timescale 1ns/1ps
`include "bsl_params.svh"

module branch_skip_logic_ops_tb;
    logic i_clock;
    logic i_rstn;
    logic i_instr_valid;
    logic [`BSL_IW_W-1:0] i_instr;
    logic [7:0] i_file_rdata;
    logic [7:0] i_upper_address_latch;
    logic [`BSL_PC_W-1:0] o_pc;
    logic [7:0] o_acc;
    logic o_zero;
    logic o_file_we;
    logic [6:0] o_file_addr;
    logic [7:0] o_file_wdata;
    logic o_flush;
    int n_fail;
    int n_checks;
    logic [`BSL_PC_W-1:0] pc_e;

    bsl_core dut (.i_clock(i_clock), .i_rstn(i_rstn), .i_instr_valid(i_instr_valid),
        .i_instr(i_instr), .i_file_rdata(i_file_rdata),
        .i_upper_address_latch(i_upper_address_latch), .o_pc(o_pc), .o_acc(o_acc),
        .o_zero(o_zero), .o_file_we(o_file_we), .o_file_addr(o_file_addr),
        .o_file_wdata(o_file_wdata), .o_flush(o_flush));

    // ----------------------------------------------------------------------
    // common tasks
    // ----------------------------------------------------------------------
    task results();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results

    task check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    // one word, then a gap cycle; outputs looked at just after the taking edge
    task exec(input logic [13:0] w, input logic [7:0] rd);
        @(posedge i_clock);
        i_instr_valid <= 1'h1;
        i_instr <= w;
        i_file_rdata <= rd;
        @(posedge i_clock);
        i_instr_valid <= 1'h0;
        #1;
        pc_e = pc_e + 15'h0001;
    endtask : exec

    task outs(input logic [7:0] acc, input logic z, input logic we, input logic fl);
        check(16'(o_acc), 16'(acc), "acc");
        check(16'(o_zero), 16'(z), "zero flag");
        check(16'(o_file_we), 16'(we), "write strobe");
        check(16'(o_flush), 16'(fl), "flush");
        check(16'(o_pc), 16'(pc_e), "pc");
    endtask : outs

    task wr(input logic [6:0] a, input logic [7:0] d);
        check(16'(o_file_addr), 16'(a), "write address");
        check(16'(o_file_wdata), 16'(d), "write data");
    endtask : wr

    // ----------------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------------
    task t_reset();
        outs(8'h00, 1'h0, 1'h0, 1'h0);
        wr(7'h00, 8'h00);
    endtask : t_reset

    task t_logic_ops();
        exec({4'he, 2'h0, 8'h00}, 8'h00);
        outs(8'h00, 1'h1, 1'h0, 1'h0);
        exec({4'he, 2'h0, 8'h5a}, 8'h00);
        outs(8'h5a, 1'h0, 1'h0, 1'h0);
        exec({6'h04, 1'h0, 7'h11}, 8'h81);
        outs(8'hdb, 1'h0, 1'h0, 1'h0);
        exec({6'h04, 1'h1, 7'h7f}, 8'h00);
        outs(8'hdb, 1'h0, 1'h1, 1'h0);
        wr(7'h7f, 8'hdb);
        exec({6'h0a, 1'h1, 7'h03}, 8'hff);
        outs(8'hdb, 1'h1, 1'h1, 1'h0);
        wr(7'h03, 8'h00);
        exec({6'h0a, 1'h0, 7'h04}, 8'h10);
        outs(8'h11, 1'h0, 1'h0, 1'h0);
        exec({6'h00, 1'h1, 7'h7f}, 8'h55);
        outs(8'h11, 1'h0, 1'h0, 1'h0);
    endtask : t_logic_ops

    // zero flag is clear on entry, so a zero result must leave it clear
    task t_dec_skip();
        exec({6'h0b, 1'h1, 7'h05}, 8'h01);
        outs(8'h11, 1'h0, 1'h1, 1'h1);
        wr(7'h05, 8'h00);
        exec({4'he, 2'h0, 8'hff}, 8'h00);
        outs(8'h11, 1'h0, 1'h0, 1'h0);
        exec({6'h0b, 1'h0, 7'h06}, 8'h02);
        outs(8'h01, 1'h0, 1'h0, 1'h0);
    endtask : t_dec_skip

    // skip followed at once by a write-back word that must be discarded
    task t_inc_skip();
        @(posedge i_clock);
        i_instr_valid <= 1'h1;
        i_instr <= {6'h0f, 1'h0, 7'h00};
        i_file_rdata <= 8'hff;
        @(posedge i_clock);
        i_instr <= {6'h0a, 1'h1, 7'h02};
        i_file_rdata <= 8'h7f;
        #1;
        pc_e = pc_e + 15'h0001;
        outs(8'h00, 1'h0, 1'h0, 1'h1);
        @(posedge i_clock);
        i_instr_valid <= 1'h0;
        #1;
        pc_e = pc_e + 15'h0001;
        outs(8'h00, 1'h0, 1'h0, 1'h0);
        exec({6'h0f, 1'h1, 7'h08}, 8'h41);
        outs(8'h00, 1'h0, 1'h1, 1'h0);
        wr(7'h08, 8'h42);
    endtask : t_inc_skip

    // second latch 8'he0 has bit 7 set and bits 4:3 clear, so only bits 6:3 give the right target
    task t_branch();
        @(posedge i_clock);
        i_upper_address_latch <= 8'h18;
        exec({3'h5, 11'h123}, 8'h00);
        pc_e = 15'h1923;
        outs(8'h00, 1'h0, 1'h0, 1'h1);
        exec({6'h0a, 1'h0, 7'h01}, 8'h07);
        outs(8'h00, 1'h0, 1'h0, 1'h0);
        @(posedge i_clock);
        i_upper_address_latch <= 8'he0;
        exec({3'h5, 11'h7ff}, 8'h00);
        pc_e = 15'h67ff;
        outs(8'h00, 1'h0, 1'h0, 1'h1);
        exec({4'he, 2'h0, 8'h00}, 8'h00);
        outs(8'h00, 1'h0, 1'h0, 1'h0);
        exec({4'he, 2'h0, 8'h00}, 8'h00);
        outs(8'h00, 1'h1, 1'h0, 1'h0);
    endtask : t_branch

    // ----------------------------------------------------------------------
    // clock, watchdog and main sequence
    // ----------------------------------------------------------------------
    initial begin
        i_clock = 1'h0;
        forever #4 i_clock = ~i_clock;
    end

    // bounds the whole run; a hang counts as a mismatch
    initial begin
        repeat (5000) @(posedge i_clock);
        n_fail++;
        $display("unexpected at %0t: run did not finish", $time);
        results();
    end

    initial begin
        i_rstn = 1'h0;
        i_instr_valid = 1'h0;
        i_instr = 14'h0000;
        i_file_rdata = 8'h00;
        i_upper_address_latch = 8'h00;
        pc_e = 15'h0000;
        n_fail = 0;
        n_checks = 0;
        repeat (5) @(posedge i_clock);
        i_rstn <= 1'h1;
        #1;
        t_reset();
        t_logic_ops();
        t_dec_skip();
        t_inc_skip();
        t_branch();
        results();
    end
endmodule : branch_skip_logic_ops_tb
